// [design/rcc_regs.sv]
// Channel one, side B configuration and status register bank of the repeater.
`timescale 1ns/1ps
module rcc_regs
  import rcc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire rcc_pkg::rcc_req_t   req,
  input  wire logic                global_override,
  input  wire logic [1:0]          pin_assert_th,
  input  wire logic [1:0]          pin_deassert_th,
  input  wire logic                receiver_detect_term,
  output rcc_pkg::rcc_rsp_t        rsp,
  output rcc_pkg::rcc_cfg_t        cfg,
  output logic [4:0]               attenuation_range_cut
);
  import rcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and register storage.

  logic       term_sync;
  logic [3:0] pin_th_raw;
  logic [3:0] pin_th_sync;
  logic       wr_amp;
  logic       wr_att;
  logic       wr_th;
  logic       wr_rsv_a;
  logic       wr_rsv_b;
  logic [7:0] amp_q;
  logic [7:0] att_q;
  logic [7:0] th_q;
  logic [7:0] rsv_a_q;
  logic [7:0] rsv_b_q;

  rcc_sync u_term_sync
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (receiver_detect_term),
    .dout    (term_sync)
  );

  // The threshold pins come from outside the clock domain, so each bit passes two flip-flops.
  assign pin_th_raw = {pin_assert_th, pin_deassert_th};

  for (genvar i = 0; i < 4; i++)
  begin : g_pin_sync
    rcc_sync u_pin_sync
    (
      .clock   (clock),
      .sys_rst (sys_rst),
      .din     (pin_th_raw[i]),
      .dout    (pin_th_sync[i])
    );
  end

  // Write decode: a strobe reaches at most one register, and writes to unmapped addresses are dropped.
  always_comb
  begin
    wr_amp   = 1'b0;
    wr_att   = 1'b0;
    wr_th    = 1'b0;
    wr_rsv_a = 1'b0;
    wr_rsv_b = 1'b0;
    if (req.wr_en)
    begin
      if (req.addr == RCC_OFS_AMPLITUDE)
        wr_amp = 1'b1;
      else if (req.addr == RCC_OFS_ATTENUATION)
        wr_att = 1'b1;
      else if (req.addr == RCC_OFS_THRESHOLDS)
        wr_th = 1'b1;
      else if (req.addr == RCC_OFS_RESERVED_A)
        wr_rsv_a = 1'b1;
      else if (req.addr == RCC_OFS_RESERVED_B)
        wr_rsv_b = 1'b1;
    end
  end

  // Reserved bits of the amplitude register are stored as written; the host keeps them at 0101.
  rcc_reg8 #(.RST_VAL(RCC_RST_AMPLITUDE), .WR_MASK(RCC_MASK_AMPLITUDE)) u_amp
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (wr_amp),
    .wdata   (req.wdata),
    .q       (amp_q)
  );

  // Bit 7 is status only and is never stored.
  rcc_reg8 #(.RST_VAL(RCC_RST_ATTENUATION), .WR_MASK(RCC_MASK_ATTENUATION)) u_att
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (wr_att),
    .wdata   (req.wdata),
    .q       (att_q)
  );

  rcc_reg8 #(.RST_VAL(RCC_RST_THRESHOLDS), .WR_MASK(RCC_MASK_THRESHOLDS)) u_th
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (wr_th),
    .wdata   (req.wdata),
    .q       (th_q)
  );

  rcc_reg8 #(.RST_VAL(RCC_RST_RESERVED), .WR_MASK(8'hFF)) u_rsv_a
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (wr_rsv_a),
    .wdata   (req.wdata),
    .q       (rsv_a_q)
  );

  rcc_reg8 #(.RST_VAL(RCC_RST_RESERVED), .WR_MASK(8'hFF)) u_rsv_b
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (wr_rsv_b),
    .wdata   (req.wdata),
    .q       (rsv_b_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output state, registered as one struct.

  typedef struct packed {
    rcc_rsp_t   rsp;
    rcc_cfg_t   cfg;
    logic [4:0] cut;
  } rcc_st_t;

  rcc_st_t st_q;
  rcc_st_t st_d;

  // Range reduction in half-dB steps for each attenuation code.
  function automatic logic [4:0] atten_tenths_halfdb(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h00;
    case (code)
      3'h0: r = 5'h00;
      3'h1: r = 5'h03;
      3'h2: r = 5'h07;
      3'h3: r = 5'h0A;
      3'h4: r = 5'h0C;
      3'h5: r = 5'h10;
      3'h6: r = 5'h12;
      default: r = 5'h18;
    endcase
    return r;
  endfunction

  always_comb
  begin
    st_d = st_q;
    st_d.rsp.rd_valid = req.rd_en;
    if (req.rd_en)
    begin
      if (req.addr == RCC_OFS_AMPLITUDE)
        st_d.rsp.rdata = amp_q;
      else if (req.addr == RCC_OFS_ATTENUATION)
        st_d.rsp.rdata = {term_sync, att_q[6:0]};
      else if (req.addr == RCC_OFS_THRESHOLDS)
        st_d.rsp.rdata = th_q;
      else if (req.addr == RCC_OFS_RESERVED_A)
        st_d.rsp.rdata = rsv_a_q;
      else if (req.addr == RCC_OFS_RESERVED_B)
        st_d.rsp.rdata = rsv_b_q;
      else
        st_d.rsp.rdata = 8'h00;
    end
    st_d.cfg.short_prot_en = amp_q[RCC_BIT_SHORT_PROT];
    st_d.cfg.swing_code    = amp_q[RCC_POS_SWING +: 3];
    st_d.cfg.atten_code    = att_q[RCC_POS_ATTEN +: 3];
    st_d.cut               = atten_tenths_halfdb(att_q[2:0]);
    // Register thresholds replace the pin choice only while override is set.
    if (global_override)
    begin
      st_d.cfg.assert_th   = th_q[RCC_POS_ASSERT_TH +: 2];
      st_d.cfg.deassert_th = th_q[RCC_POS_DEASSERT_TH +: 2];
    end
    else
    begin
      st_d.cfg.assert_th   = pin_th_sync[3:2];
      st_d.cfg.deassert_th = pin_th_sync[1:0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q                 <= '0;
      st_q.cfg.short_prot_en <= RCC_RST_AMPLITUDE[RCC_BIT_SHORT_PROT];
      st_q.cfg.swing_code  <= RCC_RST_AMPLITUDE[2:0];
      st_q.cfg.atten_code  <= RCC_RST_ATTENUATION[2:0];
      st_q.cut             <= 5'h07;
      st_q.cfg.assert_th   <= RCC_TH_DEFAULT;
      st_q.cfg.deassert_th <= RCC_TH_DEFAULT;
    end
    else
      st_q <= st_d;
  end

  assign rsp                   = st_q.rsp;
  assign cfg                   = st_q.cfg;
  assign attenuation_range_cut = st_q.cut;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_short_prot_follow: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.short_prot_en == $past(amp_q[7]))
    else $error("Short protection enable does not follow amplitude bit 7.");

  a_swing_code_follow: assert property (@(posedge clock) disable iff (sys_rst)
    req.wr_en && req.addr == RCC_OFS_AMPLITUDE |-> ##2 cfg.swing_code == $past(req.wdata[2:0], 2))
    else $error("Amplitude code not applied two cycles after write.");

  a_term_status_read: assert property (@(posedge clock) disable iff (sys_rst)
    req.rd_en && req.addr == RCC_OFS_ATTENUATION |=> rsp.rd_valid && rsp.rdata[7] == $past(term_sync))
    else $error("Termination status bit misreported.");

  a_atten_code_follow: assert property (@(posedge clock) disable iff (sys_rst)
    req.wr_en && req.addr == RCC_OFS_ATTENUATION |-> ##2 cfg.atten_code == $past(req.wdata[2:0], 2))
    else $error("Attenuation code not applied two cycles after write.");

  a_range_cut_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (attenuation_range_cut == 5'h00) == (cfg.atten_code == 3'h0))
    else $error("Range reduction disagrees with attenuation code.");

  a_assert_th_sel: assert property (@(posedge clock) disable iff (sys_rst)
    $past(global_override) |-> cfg.assert_th == $past(th_q[3:2]))
    else $error("Assert threshold not taken from register under override.");

  a_deassert_th_sel: assert property (@(posedge clock) disable iff (sys_rst)
    $past(global_override) |-> cfg.deassert_th == $past(th_q[1:0]))
    else $error("De-assert threshold not taken from register under override.");

  a_pin_th_sel: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(global_override) |->
      cfg.assert_th == $past(pin_th_sync[3:2]) && cfg.deassert_th == $past(pin_th_sync[1:0]))
    else $error("Threshold pins not used while override is clear.");

  a_short_prot_write: assert property (@(posedge clock) disable iff (sys_rst)
    wr_amp |-> ##2 cfg.short_prot_en == $past(req.wdata[7], 2))
    else $error("Short protection enable not applied two cycles after write.");

  a_amp_read_back: assert property (@(posedge clock) disable iff (sys_rst)
    wr_amp ##1 (req.rd_en && req.addr == RCC_OFS_AMPLITUDE) |=> rsp.rdata == $past(req.wdata, 2))
    else $error("Amplitude register does not read back the written value.");

  a_swing_code_stable: assert property (@(posedge clock) disable iff (sys_rst)
    !wr_amp |-> ##2 $stable(cfg.swing_code))
    else $error("Amplitude code changed without a write.");

  a_att_read_zero: assert property (@(posedge clock) disable iff (sys_rst)
    req.rd_en && req.addr == RCC_OFS_ATTENUATION |=> rsp.rdata[4:3] == 2'h0)
    else $error("Attenuation bits 4:3 do not read zero.");

  a_att_write_back: assert property (@(posedge clock) disable iff (sys_rst)
    wr_att ##1 (req.rd_en && req.addr == RCC_OFS_ATTENUATION) |=>
      rsp.rdata[6:0] == ($past(req.wdata[6:0], 2) & RCC_MASK_ATTENUATION[6:0]))
    else $error("Attenuation register does not read back the writable bits.");

  a_atten_code_stable: assert property (@(posedge clock) disable iff (sys_rst)
    !wr_att |-> ##2 $stable(cfg.atten_code))
    else $error("Attenuation code changed without a write.");

  a_range_cut_step: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.atten_code == 3'h1 |-> attenuation_range_cut == 5'h03)
    else $error("Range reduction wrong for the smallest attenuation step.");

  a_range_cut_max: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.atten_code == 3'h7 |-> attenuation_range_cut == 5'h18)
    else $error("Range reduction wrong for the largest attenuation step.");

  a_thr_write_apply: assert property (@(posedge clock) disable iff (sys_rst)
    wr_th ##1 global_override |=> cfg.assert_th == $past(req.wdata[3:2], 2))
    else $error("Written assert threshold not applied under override.");

  a_dethr_write_apply: assert property (@(posedge clock) disable iff (sys_rst)
    wr_th ##1 global_override |=> cfg.deassert_th == $past(req.wdata[1:0], 2))
    else $error("Written de-assert threshold not applied under override.");

  a_thr_read_back: assert property (@(posedge clock) disable iff (sys_rst)
    wr_th ##1 (req.rd_en && req.addr == RCC_OFS_THRESHOLDS) |=> rsp.rdata == $past(req.wdata, 2))
    else $error("Threshold register does not read back the written value.");

  a_read_valid_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> rsp.rd_valid == $past(req.rd_en))
    else $error("Read valid is not a one-cycle answer to the read strobe.");

  a_rdata_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !req.rd_en |=> $stable(rsp.rdata))
    else $error("Read data changed without a read.");

endmodule

// [design/rcc_pkg.sv]
// Package of register offsets, field layouts, reset values and carrier types for the channel register bank.
package rcc_pkg;

  localparam logic [7:0] RCC_OFS_AMPLITUDE   = 8'h17;
  localparam logic [7:0] RCC_OFS_ATTENUATION = 8'h18;
  localparam logic [7:0] RCC_OFS_THRESHOLDS  = 8'h19;
  localparam logic [7:0] RCC_OFS_RESERVED_A  = 8'h1A;
  localparam logic [7:0] RCC_OFS_RESERVED_B  = 8'h1B;
  localparam logic [7:0] RCC_OFS_GLOBAL      = 8'h08;

  localparam logic [7:0] RCC_RST_AMPLITUDE   = 8'hAD;
  localparam logic [7:0] RCC_RST_ATTENUATION = 8'h02;
  localparam logic [7:0] RCC_RST_THRESHOLDS  = 8'h00;
  localparam logic [7:0] RCC_RST_RESERVED    = 8'h00;

  localparam int RCC_BIT_SHORT_PROT   = 7;
  localparam int RCC_BIT_TERM_STATUS  = 7;
  localparam int RCC_BIT_OVERRIDE     = 6;
  localparam int RCC_POS_SWING        = 0;
  localparam int RCC_POS_ATTEN        = 0;
  localparam int RCC_POS_ASSERT_TH    = 2;
  localparam int RCC_POS_DEASSERT_TH  = 0;

  localparam logic [7:0] RCC_MASK_AMPLITUDE   = 8'hFF;
  localparam logic [7:0] RCC_MASK_ATTENUATION = 8'h67;
  localparam logic [7:0] RCC_MASK_THRESHOLDS  = 8'hFF;

  localparam logic [1:0] RCC_TH_DEFAULT = 2'h0;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcc_req_t;

  typedef struct packed {
    logic       rd_valid;
    logic [7:0] rdata;
  } rcc_rsp_t;

  typedef struct packed {
    logic       short_prot_en;
    logic [2:0] swing_code;
    logic [2:0] atten_code;
    logic [1:0] assert_th;
    logic [1:0] deassert_th;
  } rcc_cfg_t;

endpackage

// [design/rcc_sync.sv]
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module rcc_sync
  import rcc_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic meta;
    logic stable;
  } rcc_sync_st_t;

  rcc_sync_st_t st_q;
  rcc_sync_st_t st_d;

  always_comb
  begin
    st_d.meta   = din;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign dout = st_q.stable;

endmodule

// [design/rcc_reg8.sv]
// One 8-bit register with reset value, writable-bit mask and byte write strobe.
`timescale 1ns/1ps
module rcc_reg8
  import rcc_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
)
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  logic [7:0] val_q;
  logic [7:0] val_d;

  always_comb
  begin
    val_d = val_q;
    if (wr_en)
      val_d = (wdata & WR_MASK) | (val_q & ~WR_MASK);
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      val_q <= RST_VAL;
    else
      val_q <= val_d;
  end

  assign q = val_q;

endmodule

// [tb/rcc_host.sv]
// Management host model issuing single-byte register writes and reads.
`timescale 1ns/1ps
module rcc_host
  import rcc_pkg::*;
(
  input  wire logic              clock,
  output rcc_pkg::rcc_req_t      req,
  input  wire rcc_pkg::rcc_rsp_t rsp
);
  initial req = '0;
  // Released address lines show the inverse of their last value (write data too, in wr and wr_rd) so stale data never passes for fresh.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge clock);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clock);
    req <= '{1'b0, 1'b1, a, req.wdata};
    @(negedge clock);
    v = rsp.rd_valid;
    d = rsp.rdata;
    req <= '{1'b0, 1'b0, ~a, req.wdata};
  endtask
  // Write immediately followed by a read of the same address, one strobe per cycle.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d, output logic v);
    @(negedge clock);
    req <= '{1'b1, 1'b0, a, wd};
    @(negedge clock);
    req <= '{1'b0, 1'b1, a, ~wd};
    @(negedge clock);
    v = rsp.rd_valid;
    d = rsp.rdata;
    req <= '{1'b0, 1'b0, ~a, ~wd};
  endtask
endmodule

// [tb/repeater_channel_config_regs_tb.sv]
// Self-checking bench for the channel configuration register bank.
`timescale 1ns/1ps
module repeater_channel_config_regs_tb;
  import rcc_pkg::*;
  logic       clock;
  logic       sys_rst;
  logic       global_override;
  logic       receiver_detect_term;
  logic       v;
  logic [1:0] pin_assert_th;
  logic [1:0] pin_deassert_th;
  logic [4:0] attenuation_range_cut;
  logic [7:0] d;
  rcc_req_t   req;
  rcc_rsp_t   rsp;
  rcc_cfg_t   cfg;
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         cycles = 0;
  localparam logic [4:0] CUT [8] = '{5'h00, 5'h03, 5'h07, 5'h0A, 5'h0C, 5'h10, 5'h12, 5'h18};

  rcc_regs i_rcc_regs (
    .clock                (clock),
    .sys_rst              (sys_rst),
    .req                  (req),
    .global_override      (global_override),
    .pin_assert_th        (pin_assert_th),
    .pin_deassert_th      (pin_deassert_th),
    .receiver_detect_term (receiver_detect_term),
    .rsp                  (rsp),
    .cfg                  (cfg),
    .attenuation_range_cut(attenuation_range_cut)
  );
  rcc_host i_rcc_host (
    .clock(clock),
    .req  (req),
    .rsp  (rsp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_rcc_host.rd(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({7'h00, cfg.short_prot_en}, 8'h01);
    check({5'h00, cfg.swing_code}, 8'h05);
    check({5'h00, cfg.atten_code}, 8'h02);
    check({3'h0, attenuation_range_cut}, 8'h07);
    check({4'h0, cfg.assert_th, cfg.deassert_th}, 8'h00);
    rd_chk(8'h17, 8'hAD);
    rd_chk(8'h18, 8'h02);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h1A, 8'h00);
    rd_chk(8'h1B, 8'h00);
  endtask

  task automatic t_amp();
    logic [7:0] val;
    for (int c = 0; c < 8; c++)
    begin
      val = {c[0], 4'h5, c[2:0]};
      i_rcc_host.wr(8'h17, val);
      @(negedge clock);
      check({7'h00, cfg.short_prot_en}, {7'h00, c[0]});
      check({5'h00, cfg.swing_code}, {5'h00, c[2:0]});
      rd_chk(8'h17, val);
    end
    i_rcc_host.wr(8'h17, 8'hAE);
  endtask

  task automatic t_att();
    for (int c = 0; c < 8; c++)
    begin
      receiver_detect_term = c[1];
      i_rcc_host.wr(8'h18, {5'h00, c[2:0]});
      @(negedge clock);
      check({5'h00, cfg.atten_code}, {5'h00, c[2:0]});
      check({3'h0, attenuation_range_cut}, {3'h0, CUT[c]});
      rd_chk(8'h18, {c[1], 4'h0, c[2:0]});
    end
    receiver_detect_term = 1'b0;
  endtask

  task automatic t_thr();
    for (int c = 0; c < 16; c++)
    begin
      i_rcc_host.wr(8'h19, {4'h0, c[3:0]});
      global_override = 1'b0;
      {pin_assert_th, pin_deassert_th} = ~c[3:0];
      repeat (3) @(negedge clock);
      check({4'h0, cfg.assert_th, cfg.deassert_th}, {4'h0, ~c[3:0]});
      global_override = 1'b1;
      repeat (3) @(negedge clock);
      check({4'h0, cfg.assert_th, cfg.deassert_th}, {4'h0, c[3:0]});
      rd_chk(8'h19, {4'h0, c[3:0]});
    end
    global_override = 1'b0;
    {pin_assert_th, pin_deassert_th} = 4'h0;
  endtask

  task automatic t_b2b();
    global_override = 1'b1;
    i_rcc_host.wr_rd(8'h17, 8'hAE, d, v);
    check({7'h00, v}, 8'h01);
    check(d, 8'hAE);
    i_rcc_host.wr_rd(8'h18, 8'h04, d, v);
    check(d, 8'h04);
    i_rcc_host.wr_rd(8'h19, 8'h0B, d, v);
    check(d, 8'h0B);
    check({5'h00, cfg.atten_code}, 8'h04);
    check({3'h0, attenuation_range_cut}, {3'h0, CUT[4]});
    check({4'h0, cfg.assert_th, cfg.deassert_th}, 8'h0B);
    global_override = 1'b0;
  endtask

  task automatic t_unmap();
    rd_chk(8'h20, 8'h00);
    i_rcc_host.wr(8'h20, 8'h5A);
    rd_chk(8'h17, 8'hAE);
    i_rcc_host.wr(8'h1A, 8'h00);
    rd_chk(8'h1A, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    global_override = 1'b0;
    receiver_detect_term = 1'b0;
    pin_assert_th = 2'h0;
    pin_deassert_th = 2'h0;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_amp();
    t_att();
    t_thr();
    t_b2b();
    t_unmap();
    // A reset in mid-run must bring every register back to its default.
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (3) @(negedge clock);
    t_reset();
    finish_test();
  end
endmodule
